// ===== rtl/adc_config_register_bank.sv
// Purpose: APB register bank for a delta-sigma converter front end
// Assumes: 250 MHz pclk; ext_osc_active is an asynchronous status level
// Notes: Reads answer after two access cycles; writes after one
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps
// Operation
// (R1) Fifteen byte registers, indexes 00h to 0Eh
// (R2) Burnout field maps to off/0.5/2/10 uA
// (R3) Positive select routes input of that index
// (R4) Negative select routes input, default input one
// (R5) Monitor or bias overrides channel selection
// (R6) Each bias bit biases input of same index
// (R7) Bias register at 01h resets to zero
// (R8) Register 02h resets zero, four fields
// (R9) Coefficients are 24 bits, low byte first
// (R10) Monitor select beats channel and bias
// (R11) Oscillator flag read-only, one means external
module adc_config_register_bank
    import adc_cfg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_osc_active,
    output logic [1:0] burnout_current_level,
    output logic [2:0] positive_input_select,
    output logic [2:0] negative_input_select,
    output logic routing_normal,
    output logic [7:0] midsupply_bias_bits,
    output logic [2:0] monitor_source_select,
    output logic [1:0] reference_power_control,
    output logic [1:0] reference_input_select,
    output logic [2:0] gain_select,
    output logic [3:0] output_rate_select,
    output logic [23:0] offset_coefficient,
    output logic [23:0] fullscale_coefficient,
    output logic ready_pin_mode,
    output logic [2:0] current_magnitude,
    output logic [7:0] current_output_route,
    output logic [7:0] pin_function,
    output logic [7:0] pin_direction,
    output logic [7:0] pin_level
);
    // Decode helpers
    function automatic logic addr_valid(input logic [31:0] a);
        return (a[1:0] == 2'b00) && (a[31:6] == 26'h0) && (a[5:2] <= IDX_LAST);
    endfunction

    function automatic logic [3:0] addr_index(input logic [31:0] a);
        return a[5:2];
    endfunction

    logic osc_meta;
    logic osc_sync;
    logic rd_wait;
    logic wr_en;
    logic [7:0] rd_byte;
    logic [8*REG_COUNT-1:0] flat;
    logic [7:0] wr_byte;
    logic [7:0] r_chan;
    logic [7:0] r_bias;
    logic [7:0] r_mux;
    logic [7:0] r_sys;
    logic [7:0] r_idac;
    logic [2:0] mon;
    logic [2:0] next_pos;
    logic [2:0] next_neg;
    logic [7:0] next_bias;
    logic next_normal;

    // Two-stage synchroniser for the oscillator status level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
        end else begin
            osc_meta <= ext_osc_active;
            osc_sync <= osc_meta;
        end
    end

    // Write strobe in the access phase; status bit is never stored
    always_comb begin
        wr_en = psel && penable && pwrite && addr_valid(paddr); // (R1)
        wr_byte = pwdata[7:0];
        if (addr_index(paddr) == IDX_REFERENCE_MONITOR_CONTROL) begin
            wr_byte[OSC_FLAG_BIT] = 1'b0; // (R11)
        end
    end

    adc_reg_store store (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_en),
        .wr_idx(addr_index(paddr)),
        .wr_data(wr_byte),
        .rd_idx(addr_index(paddr)),
        .rd_data(rd_byte),
        .flat(flat)
    );

    assign r_chan = flat[8*IDX_CHANNEL_SELECT_BURNOUT +: 8];
    assign r_bias = flat[8*IDX_MIDSUPPLY_BIAS_ENABLE +: 8]; // (R7)
    assign r_mux = flat[8*IDX_REFERENCE_MONITOR_CONTROL +: 8]; // (R8)
    assign r_sys = flat[8*IDX_GAIN_RATE_CONTROL +: 8];
    assign r_idac = flat[8*IDX_REVISION_READY_CURRENT_LEVEL +: 8];
    assign mon = r_mux[MONITOR_LSB +: 3];

    // APB handshake: reads wait one cycle for the registered store
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_wait <= 1'b0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= READ_ZERO;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            if (psel && penable && !pready) begin
                if (pwrite || !addr_valid(paddr)) begin
                    pready <= 1'b1;
                    pslverr <= !addr_valid(paddr);
                    prdata <= READ_ZERO;
                end else if (!rd_wait) begin
                    rd_wait <= 1'b1;
                end else begin
                    rd_wait <= 1'b0;
                    pready <= 1'b1;
                    prdata <= {24'h000000, rd_byte};
                    if (addr_index(paddr) == IDX_REFERENCE_MONITOR_CONTROL) begin
                        prdata[OSC_FLAG_BIT] <= osc_sync; // (R11)
                    end
                    if (addr_index(paddr) == IDX_REVISION_READY_CURRENT_LEVEL) begin
                        prdata[7:4] <= REVISION_ID;
                    end
                end
            end
        end
    end

    // Effective input routing: monitor first, then bias, then channel fields
    always_comb begin
        next_pos = r_chan[POS_SEL_LSB +: 3]; // (R3)
        next_neg = r_chan[NEG_SEL_LSB +: 3]; // (R4)
        next_bias = r_bias; // (R6)
        next_normal = 1'b1;
        if (mon != MONITOR_NORMAL) begin
            next_bias = 8'h00; // (R10)
            next_normal = 1'b0; // (R5)
        end else if (r_bias != 8'h00) begin
            next_normal = 1'b0; // (R5)
        end
    end

    // Registered control outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            burnout_current_level <= 2'b00;
            positive_input_select <= 3'h0;
            negative_input_select <= 3'h1;
            routing_normal <= 1'b1;
            midsupply_bias_bits <= 8'h00;
            monitor_source_select <= 3'h0;
            reference_power_control <= 2'b00;
            reference_input_select <= 2'b00;
            gain_select <= 3'h0;
            output_rate_select <= 4'h0;
            offset_coefficient <= 24'h000000;
            fullscale_coefficient <= 24'h000000;
            ready_pin_mode <= 1'b0;
            current_magnitude <= 3'h0;
            current_output_route <= 8'h00;
            pin_function <= 8'h00;
            pin_direction <= 8'h00;
            pin_level <= 8'h00;
        end else begin
            burnout_current_level <= r_chan[BURNOUT_LSB +: 2]; // (R2)
            positive_input_select <= next_pos; // (R3)
            negative_input_select <= next_neg; // (R4)
            routing_normal <= next_normal; // (R5)
            midsupply_bias_bits <= next_bias; // (R6)
            monitor_source_select <= mon; // (R10)
            reference_power_control <= r_mux[REF_POWER_LSB +: 2]; // (R8)
            reference_input_select <= r_mux[REF_INPUT_LSB +: 2]; // (R8)
            gain_select <= r_sys[GAIN_LSB +: 3];
            output_rate_select <= r_sys[RATE_LSB +: 4];
            offset_coefficient <= flat[8*IDX_OFFSET_COEFF_LOW +: 24]; // (R9)
            fullscale_coefficient <= flat[8*IDX_FULLSCALE_COEFF_LOW +: 24]; // (R9)
            ready_pin_mode <= r_idac[3];
            current_magnitude <= r_idac[2:0];
            current_output_route <= flat[8*IDX_CURRENT_OUTPUT_ROUTING +: 8];
            pin_function <= flat[8*IDX_PIN_FUNCTION_SELECT +: 8];
            pin_direction <= flat[8*IDX_PIN_DIRECTION_CONTROL +: 8];
            pin_level <= flat[8*IDX_PIN_LEVEL_VALUE +: 8];
        end
    end

    // Checks
    AST_UNMAPPED_ERR: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && !addr_valid(paddr) |=> pready && pslverr) // (R1)
        else $error("unmapped access not flagged");
    AST_BURNOUT_MAP: assert property (@(posedge pclk) disable iff (!presetn)
        burnout_current_level == $past(r_chan[7:6])) // (R2)
        else $error("burnout level mismatch");
    AST_POS_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
        positive_input_select == $past(r_chan[5:3])) // (R3)
        else $error("positive select mismatch");
    AST_NEG_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
        negative_input_select == $past(r_chan[2:0])) // (R4)
        else $error("negative select mismatch");
    AST_OVERRIDE: assert property (@(posedge pclk) disable iff (!presetn)
        (mon != MONITOR_NORMAL || r_bias != 8'h00) |=> !routing_normal) // (R5)
        else $error("override not applied");
    AST_BIAS_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        mon == MONITOR_NORMAL |=> midsupply_bias_bits == $past(r_bias)) // (R6)
        else $error("bias bits mismatch");
    AST_MONITOR_WINS: assert property (@(posedge pclk) disable iff (!presetn)
        mon != MONITOR_NORMAL |=> midsupply_bias_bits == 8'h00) // (R10)
        else $error("monitor did not suppress bias");
    AST_OSC_RO: assert property (@(posedge pclk) disable iff (!presetn)
        r_mux[OSC_FLAG_BIT] == 1'b0) // (R11)
        else $error("oscillator flag stored");
    AST_COEFF: assert property (@(posedge pclk) disable iff (!presetn)
        offset_coefficient[7:0] == $past(flat[39:32])) // (R9)
        else $error("offset low byte mismatch");

    // Bus handshake timing and refusal checks
    AST_WRITE_ANSWER: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && pwrite
        |=> pready) // (R1)
        else $error("write not answered in one cycle");

    AST_READ_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && !pwrite && addr_valid(paddr) && !rd_wait
        |=> !pready) // (R1)
        else $error("read answered without wait state");

    AST_READ_ANSWER: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && !pwrite && rd_wait
        |=> pready) // (R1)
        else $error("read not answered after wait state");

    AST_READY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
        pready
        |=> !pready) // (R1)
        else $error("ready held longer than one cycle");

    AST_ERR_WITH_READY: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr
        |-> pready) // (R1)
        else $error("error flag without ready");

    AST_READ_UPPER_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        pready
        |-> prdata[31:8] == 24'h000000) // (R1)
        else $error("upper read data not zero");

    AST_MAPPED_NO_ERR: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && addr_valid(paddr)
        |=> !pslverr) // (R1)
        else $error("mapped access flagged as error");

    AST_IGNORED_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pwrite && !addr_valid(paddr)
        |=> $stable(flat)) // (R1)
        else $error("refused write changed storage");

    AST_WRITE_LANDS: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en
        |=> flat[8*$past(addr_index(paddr)) +: 8] == $past(wr_byte)) // (R1)
        else $error("write did not land");

    // Read view of status and revision bits
    AST_OSC_READ: assert property (@(posedge pclk) disable iff (!presetn)
        pready && !pwrite && !pslverr && addr_index(paddr) == IDX_REFERENCE_MONITOR_CONTROL
        |-> prdata[OSC_FLAG_BIT] == $past(osc_sync)) // (R11)
        else $error("oscillator flag not read back");

    AST_REVISION_READ: assert property (@(posedge pclk) disable iff (!presetn)
        pready && !pwrite && !pslverr && addr_index(paddr) == IDX_REVISION_READY_CURRENT_LEVEL
        |-> prdata[7:4] == REVISION_ID)
        else $error("revision nibble not read back");

    // Control outputs follow register contents one cycle late
    AST_REF_POWER: assert property (@(posedge pclk) disable iff (!presetn)
        reference_power_control
        == $past(r_mux[6:5])) // (R8)
        else $error("reference power mismatch");

    AST_REF_INPUT: assert property (@(posedge pclk) disable iff (!presetn)
        reference_input_select
        == $past(r_mux[4:3])) // (R8)
        else $error("reference input mismatch");

    AST_MONITOR_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        monitor_source_select
        == $past(mon)) // (R10)
        else $error("monitor select mismatch");

    AST_OFFSET_FULL: assert property (@(posedge pclk) disable iff (!presetn)
        offset_coefficient
        == $past(flat[55:32])) // (R9)
        else $error("offset coefficient mismatch");

    AST_FULLSCALE_FULL: assert property (@(posedge pclk) disable iff (!presetn)
        fullscale_coefficient
        == $past(flat[79:56])) // (R9)
        else $error("full-scale coefficient mismatch");

    AST_NORMAL_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
        mon == MONITOR_NORMAL && r_bias == 8'h00
        |=> routing_normal) // (R5)
        else $error("normal routing not restored");

    AST_GAIN_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        gain_select
        == $past(r_sys[6:4]))
        else $error("gain select mismatch");

    AST_RATE_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        output_rate_select
        == $past(r_sys[3:0]))
        else $error("rate select mismatch");

    AST_READY_MODE_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        ready_pin_mode
        == $past(r_idac[3]))
        else $error("ready pin mode mismatch");

    AST_MAGNITUDE_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        current_magnitude
        == $past(r_idac[2:0]))
        else $error("current magnitude mismatch");

    AST_ROUTE_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        current_output_route
        == $past(flat[95:88]))
        else $error("current route mismatch");

    AST_PIN_FUNC_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        pin_function
        == $past(flat[103:96]))
        else $error("pin function mismatch");

    AST_PIN_DIR_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        pin_direction
        == $past(flat[111:104]))
        else $error("pin direction mismatch");

    AST_PIN_LEVEL_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        pin_level
        == $past(flat[119:112]))
        else $error("pin level mismatch");
endmodule

// ===== rtl/adc_cfg_pkg.sv
// Purpose: Constants for the converter configuration register bank
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Printed offsets are register indexes; byte address is four times the index
package adc_cfg_pkg;
    localparam int REG_COUNT = 15;
    localparam logic [3:0] IDX_CHANNEL_SELECT_BURNOUT = 4'h0;
    localparam logic [3:0] IDX_MIDSUPPLY_BIAS_ENABLE = 4'h1;
    localparam logic [3:0] IDX_REFERENCE_MONITOR_CONTROL = 4'h2;
    localparam logic [3:0] IDX_GAIN_RATE_CONTROL = 4'h3;
    localparam logic [3:0] IDX_OFFSET_COEFF_LOW = 4'h4;
    localparam logic [3:0] IDX_OFFSET_COEFF_MID = 4'h5;
    localparam logic [3:0] IDX_OFFSET_COEFF_HIGH = 4'h6;
    localparam logic [3:0] IDX_FULLSCALE_COEFF_LOW = 4'h7;
    localparam logic [3:0] IDX_FULLSCALE_COEFF_MID = 4'h8;
    localparam logic [3:0] IDX_FULLSCALE_COEFF_HIGH = 4'h9;
    localparam logic [3:0] IDX_REVISION_READY_CURRENT_LEVEL = 4'hA;
    localparam logic [3:0] IDX_CURRENT_OUTPUT_ROUTING = 4'hB;
    localparam logic [3:0] IDX_PIN_FUNCTION_SELECT = 4'hC;
    localparam logic [3:0] IDX_PIN_DIRECTION_CONTROL = 4'hD;
    localparam logic [3:0] IDX_PIN_LEVEL_VALUE = 4'hE;
    localparam logic [3:0] IDX_LAST = 4'hE;
    // Reset values
    localparam logic [7:0] RST_CHANNEL_SELECT_BURNOUT = 8'h01;
    localparam logic [7:0] RST_MIDSUPPLY_BIAS_ENABLE = 8'h00;
    localparam logic [7:0] RST_REFERENCE_MONITOR_CONTROL = 8'h00;
    localparam logic [7:0] RST_OTHER = 8'h00;
    // Field positions
    localparam int BURNOUT_LSB = 6;
    localparam int POS_SEL_LSB = 3;
    localparam int NEG_SEL_LSB = 0;
    localparam int OSC_FLAG_BIT = 7;
    localparam int REF_POWER_LSB = 5;
    localparam int REF_INPUT_LSB = 3;
    localparam int MONITOR_LSB = 0;
    localparam int GAIN_LSB = 4;
    localparam int RATE_LSB = 0;
    localparam logic [2:0] MONITOR_NORMAL = 3'h0;
    localparam logic [2:0] MONITOR_OFFSET = 3'h1;
    localparam logic [3:0] REVISION_ID = 4'h5; // Arbitrary value
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
    typedef enum logic [1:0] {
        BURNOUT_OFF,
        BURNOUT_HALF_UA,
        BURNOUT_TWO_UA,
        BURNOUT_TEN_UA
    } burnout_type;
endpackage

// ===== rtl/adc_reg_store.sv
// Purpose: Byte register storage with registered read data
// Assumes: One write port and one read port on pclk
// Notes: Reset values come from the package
`timescale 1ns/10ps
module adc_reg_store
    import adc_cfg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire logic [7:0] wr_data,
    input wire logic [3:0] rd_idx,
    output logic [7:0] rd_data,
    output logic [8*REG_COUNT-1:0] flat
);
    logic [7:0] mem [REG_COUNT];

    // Storage with documented reset values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                mem[i] <= RST_OTHER;
            end
            mem[IDX_CHANNEL_SELECT_BURNOUT] <= RST_CHANNEL_SELECT_BURNOUT;
        end else if (wr_en && wr_idx <= IDX_LAST) begin
            mem[wr_idx] <= wr_data;
        end
    end

    // Registered read port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data <= 8'h00;
        end else if (rd_idx <= IDX_LAST) begin
            rd_data <= mem[rd_idx];
        end else begin
            rd_data <= 8'h00;
        end
    end

    // Flattened view for routing logic
    always_comb begin
        for (int i = 0; i < REG_COUNT; i++) begin
            flat[8*i +: 8] = mem[i];
        end
    end
endmodule

// ===== testbench/apb_host_model.sv
// Purpose: APB host model that issues single transfers to the register bank
// Assumes: Slave answers with pready sampled at rising pclk edges
// Notes: Released address and data lines show inverted values
`timescale 1ns/10ps
module apb_host_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
    end
    // Setup, access held until pready, then release
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~addr;
        pwdata <= ~wd;
    endtask
endmodule

// ===== testbench/adc_config_register_bank_tb_top.sv
// Purpose: Self-checking bench for the converter configuration register bank
// Assumes: Outputs follow register contents one cycle late
// Notes: Byte address is four times the register index
`timescale 1ns/10ps
module adc_config_register_bank_tb_top;
    import adc_cfg_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_osc_active, err;
    logic routing_normal, ready_pin_mode;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [1:0] burnout_current_level, reference_power_control, reference_input_select;
    logic [2:0] positive_input_select, negative_input_select, monitor_source_select;
    logic [2:0] gain_select, current_magnitude;
    logic [3:0] output_rate_select;
    logic [7:0] midsupply_bias_bits, current_output_route, pin_function, pin_direction, pin_level;
    logic [23:0] offset_coefficient, fullscale_coefficient;
    logic [7:0] pat [REG_COUNT];
    int n_mismatch, n_checks;
    apb_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    adc_config_register_bank u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_osc_active(ext_osc_active),
        .burnout_current_level(burnout_current_level),
        .positive_input_select(positive_input_select),
        .negative_input_select(negative_input_select), .routing_normal(routing_normal),
        .midsupply_bias_bits(midsupply_bias_bits), .monitor_source_select(monitor_source_select),
        .reference_power_control(reference_power_control),
        .reference_input_select(reference_input_select), .gain_select(gain_select),
        .output_rate_select(output_rate_select), .offset_coefficient(offset_coefficient),
        .fullscale_coefficient(fullscale_coefficient), .ready_pin_mode(ready_pin_mode),
        .current_magnitude(current_magnitude), .current_output_route(current_output_route),
        .pin_function(pin_function), .pin_direction(pin_direction), .pin_level(pin_level));
    // Clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        u_host.xfer(1'b1, {26'h0, idx, 2'h0}, {24'h0, d}, rd, err);
        check(32'(err), 32'h0000_0000);
    endtask
    task automatic rdchk(input logic [3:0] idx, input logic [7:0] exp);
        u_host.xfer(1'b0, {26'h0, idx, 2'h0}, 32'h0000_0000, rd, err);
        check(rd, {24'h0, exp});
        check(32'(err), 32'h0000_0000);
    endtask
    // Read view: oscillator flag and revision nibble replace stored bits
    function automatic logic [7:0] view(input logic [3:0] idx, input logic [7:0] d);
        if (idx == IDX_REFERENCE_MONITOR_CONTROL) return {ext_osc_active, d[6:0]};
        if (idx == IDX_REVISION_READY_CURRENT_LEVEL) return {REVISION_ID, d[3:0]};
        return d;
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (5000) @(posedge pclk);
        n_mismatch++;
        summarize();
    end
    // Main sequence
    initial begin
        presetn = 1'b0;
        ext_osc_active = 1'b0;
        n_mismatch = 0;
        n_checks = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        check(32'(negative_input_select), 32'h1);
        check(32'(routing_normal), 32'h1);
        check(32'(midsupply_bias_bits), 32'h0);
        for (int i = 0; i < REG_COUNT; i++) begin
            rdchk(4'(i), (i == 0) ? RST_CHANNEL_SELECT_BURNOUT : view(4'(i), RST_OTHER));
        end
        // Distinct byte in every register, then read back
        for (int i = 0; i < REG_COUNT; i++) begin
            pat[i] = 8'(i * 37 + 90);
            wr(4'(i), pat[i]);
        end
        for (int i = 0; i < REG_COUNT; i++) rdchk(4'(i), view(4'(i), pat[i]));
        check(32'(offset_coefficient), {8'h0, pat[6], pat[5], pat[4]});
        check(32'(fullscale_coefficient), {8'h0, pat[9], pat[8], pat[7]});
        check(32'(reference_power_control), 32'(pat[2][6:5]));
        check(32'(reference_input_select), 32'(pat[2][4:3]));
        check(32'(monitor_source_select), 32'(pat[2][2:0]));
        check(32'(midsupply_bias_bits), 32'h0);
        check(32'(gain_select), 32'(pat[3][6:4]));
        check(32'(output_rate_select), 32'(pat[3][3:0]));
        check(32'(ready_pin_mode), 32'(pat[10][3]));
        check(32'(current_magnitude), 32'(pat[10][2:0]));
        check(32'(current_output_route), 32'(pat[11]));
        check(32'(pin_function), 32'(pat[12]));
        check(32'(pin_direction), 32'(pat[13]));
        check(32'(pin_level), 32'(pat[14]));
        // Every burnout code with fixed input selects
        wr(IDX_REFERENCE_MONITOR_CONTROL, 8'h00);
        wr(IDX_MIDSUPPLY_BIAS_ENABLE, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(IDX_CHANNEL_SELECT_BURNOUT, {2'(c), 3'h6, 3'h3});
            repeat (2) @(posedge pclk);
            check(32'(burnout_current_level), 32'(c));
            check(32'(positive_input_select), 32'h6);
            check(32'(negative_input_select), 32'h3);
            check(32'(routing_normal), 32'h1);
        end
        // Bias bits, then monitor overriding them
        wr(IDX_MIDSUPPLY_BIAS_ENABLE, 8'h81);
        repeat (2) @(posedge pclk);
        check(32'(midsupply_bias_bits), 32'h81);
        check(32'(routing_normal), 32'h0);
        wr(IDX_REFERENCE_MONITOR_CONTROL, {5'h00, MONITOR_OFFSET});
        repeat (2) @(posedge pclk);
        check(32'(monitor_source_select), 32'h1);
        check(32'(midsupply_bias_bits), 32'h0);
        check(32'(routing_normal), 32'h0);
        // External oscillator flag still reads one after a write of zero, which clears the monitor
        ext_osc_active <= 1'b1;
        repeat (4) @(posedge pclk);
        wr(IDX_REFERENCE_MONITOR_CONTROL, 8'h00);
        rdchk(IDX_REFERENCE_MONITOR_CONTROL, 8'h80);
        check(32'(midsupply_bias_bits), 32'h81);
        // Unmapped index and misaligned address are refused
        u_host.xfer(1'b1, 32'h0000_003C, 32'h0000_00FF, rd, err);
        check(32'(err), 32'h1);
        u_host.xfer(1'b0, 32'h0000_003C, 32'h0000_0000, rd, err);
        check(32'(err), 32'h1);
        check(rd, 32'h0000_0000);
        u_host.xfer(1'b1, 32'h0000_0001, 32'h0000_0000, rd, err);
        check(32'(err), 32'h1);
        rdchk(IDX_CHANNEL_SELECT_BURNOUT, 8'hF3);
        // Second reset in mid-run restores documented values
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        check(32'(negative_input_select), 32'h1);
        check(32'(burnout_current_level), 32'h0);
        check(32'(midsupply_bias_bits), 32'h0);
        rdchk(IDX_CHANNEL_SELECT_BURNOUT, RST_CHANNEL_SELECT_BURNOUT);
        rdchk(IDX_MIDSUPPLY_BIAS_ENABLE, RST_MIDSUPPLY_BIAS_ENABLE);
        rdchk(IDX_REFERENCE_MONITOR_CONTROL, 8'h80);
        summarize();
    end
endmodule
